// [src/ssc_top.sv]
// select control block: ahb-lite registers, master select drive, slave select decode
// What this block does
// - at the end of a slave transaction the match flag shows whether the bit count fit.
// - the match flag is read only and clears four peripheral clocks plus one cycle after go.
// - with fifo mode on the match flag means nothing and is held at zero.
// - slave select in edge mode turns active only after the entry edge.
// - slave select in level mode is active while the pin sits at the active level.
// - polarity 0 means low or falling active, polarity 1 high or rising active.
// - with auto select off the master pin follows the control bit at any time.
// - with auto select on the master pin is active only while a transfer runs.
// - with auto select off control 0 drives inactive and 1 drives active.
// - with auto select on control 0 keeps inactive and 1 allows activity in transfers.
// - level trigger acts only in slave role, auto select and control only as master.
// - writing go starts a master transfer or arms the slave for one transaction.
// - bit length 8 to 31 is the count and 0 means 32; 1 to 7 are unusable.
`timescale 1ns/1ns
`include "ssc_consts.svh"
module ssc_top (
  input wire logic i_mclk, // system clock, 50 MHz
  input wire logic i_resetn, // asynchronous reset, active low
  input wire logic i_hsel, // ahb slave select
  input wire logic [31:0] i_haddr, // ahb address
  input wire logic [1:0] i_htrans, // ahb transfer type
  input wire logic i_hwrite, // ahb write
  input wire logic [2:0] i_hsize, // ahb size, word only
  input wire logic [31:0] i_hwdata, // ahb write data
  output logic [31:0] o_hrdata, // ahb read data
  output logic o_hreadyout, // ahb ready
  output logic o_hresp, // ahb response, always okay
  input wire logic i_spi_pclk, // spi peripheral clock
  input wire logic i_sclk, // spi bus clock from external master
  input wire logic i_ss_in, // select pin level
  output logic o_ss_out, // select pin drive value
  output logic o_ss_oe, // select pin output enable
  output logic o_busy, // transfer go or busy
  output logic o_irq // interrupt, active high level
);
  logic rst_a_ff;
  logic rst_n;
  logic [2:0] sync_q;
  logic pclk_s;
  logic sclk_s;
  logic ss_s;
  logic pclk_d_ff;
  logic sclk_d_ff;
  logic pclk_rise;
  logic sclk_rise;
  logic addr_ok;
  logic wr_ph_ff;
  logic rd_ph_ff;
  logic [7:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic hready_ff;
  logic hresp_ff;
  logic [31:0] rdata;
  logic wr_ctrl;
  logic wr_sel;
  logic go_wr;
  logic role_mst_ff;
  logic fifo_en_ff;
  logic [4:0] bit_len_ff;
  logic go_ff;
  logic sel_ctl_ff;
  logic sel_pol_ff;
  logic auto_en_ff;
  logic ltrig_en_ff;
  logic flag_ff;
  logic [1:0] ist_ff;
  logic [1:0] imsk_ff;
  logic [1:0] ev_set;
  logic [5:0] target;
  ssc_pkg::ssc_mst_state_t mst_st_ff;
  logic [5:0] mst_cnt_ff;
  logic mst_done;
  logic sel_act;
  logic sel_end;
  logic [5:0] slv_cnt_ff;
  logic slv_done;
  logic len_hit;
  logic clr_run_ff;
  logic [2:0] clr_cnt_ff;
  logic flag_clr;
  logic ss_drive_act;
  logic ss_out_ff;
  logic ss_oe_ff;
  logic busy_ff;
  logic irq_ff;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_a_ff <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_n <= rst_a_ff;
    end
  end

  // peripheral clock, bus clock and select pin all come from outside
  ssc_sync #(.W(3)) u_sync (
    .i_clk(i_mclk),
    .i_rst_n(rst_n),
    .i_d({i_ss_in, i_sclk, i_spi_pclk}),
    .o_q(sync_q)
  );
  assign pclk_s = sync_q[0];
  assign sclk_s = sync_q[1];
  assign ss_s = sync_q[2];

  // edge finders on the synchronised copies
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_d_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
    end else begin
      pclk_d_ff <= pclk_s;
      sclk_d_ff <= sclk_s;
    end
  end
  assign pclk_rise = pclk_s & ~pclk_d_ff;
  assign sclk_rise = sclk_s & ~sclk_d_ff;

  // ahb-lite slave: writes without wait, reads take one wait state
  assign addr_ok = i_hsel & i_htrans[1] & hready_ff;
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ph_ff <= 1'b0;
      rd_ph_ff <= 1'b0;
      addr_ff <= 8'h00;
      hrdata_ff <= `SSC_ZERO32;
      hready_ff <= 1'b1;
      hresp_ff <= `SSC_RESP_OKAY;
    end else begin
      hresp_ff <= `SSC_RESP_OKAY;
      if (rd_ph_ff) begin
        hrdata_ff <= rdata;
        hready_ff <= 1'b1;
        rd_ph_ff <= 1'b0;
        wr_ph_ff <= 1'b0;
      end else if (addr_ok) begin
        wr_ph_ff <= i_hwrite;
        rd_ph_ff <= ~i_hwrite;
        addr_ff <= i_haddr[7:0];
        hready_ff <= i_hwrite;
      end else begin
        wr_ph_ff <= 1'b0;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata = `SSC_ZERO32;
    if (addr_ff == `SSC_ADDR_CTRL) begin
      rdata[`SSC_CTL_GO] = role_mst_ff ? go_ff : 1'b1; // slave always reads busy
      rdata[`SSC_CTL_MST] = role_mst_ff;
      rdata[`SSC_CTL_FIFO] = fifo_en_ff;
      rdata[`SSC_CTL_LEN_HI:`SSC_CTL_LEN_LO] = bit_len_ff;
    end else if (addr_ff == `SSC_ADDR_SEL) begin
      rdata[`SSC_SEL_CTL] = sel_ctl_ff;
      rdata[`SSC_SEL_POL] = sel_pol_ff;
      rdata[`SSC_SEL_AUTO] = auto_en_ff;
      rdata[`SSC_SEL_LTRIG] = ltrig_en_ff;
      rdata[`SSC_SEL_FLAG] = flag_ff;
    end else if (addr_ff == `SSC_ADDR_IST) begin
      rdata[1:0] = ist_ff;
    end else if (addr_ff == `SSC_ADDR_IMSK) begin
      rdata[1:0] = imsk_ff;
    end
  end

  assign wr_ctrl = wr_ph_ff & (addr_ff == `SSC_ADDR_CTRL);
  assign wr_sel = wr_ph_ff & (addr_ff == `SSC_ADDR_SEL);
  assign go_wr = wr_ctrl & i_hwdata[`SSC_CTL_GO];

  // control register; role and length should be set before go
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      role_mst_ff <= 1'b0;
      fifo_en_ff <= 1'b0;
      bit_len_ff <= `SSC_LEN_ZERO;
    end else if (wr_ctrl) begin
      role_mst_ff <= i_hwdata[`SSC_CTL_MST];
      fifo_en_ff <= i_hwdata[`SSC_CTL_FIFO];
      bit_len_ff <= i_hwdata[`SSC_CTL_LEN_HI:`SSC_CTL_LEN_LO];
    end
  end

  // select register writable fields; flag and reserved bits ignore writes
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ctl_ff <= 1'b0;
      sel_pol_ff <= 1'b0;
      auto_en_ff <= 1'b0;
      ltrig_en_ff <= 1'b0;
    end else if (wr_sel) begin
      sel_ctl_ff <= i_hwdata[`SSC_SEL_CTL];
      sel_pol_ff <= i_hwdata[`SSC_SEL_POL];
      auto_en_ff <= i_hwdata[`SSC_SEL_AUTO];
      ltrig_en_ff <= i_hwdata[`SSC_SEL_LTRIG];
    end
  end

  // zero length means a full 32-bit word; 1..7 are passed through unchecked
  assign target = (bit_len_ff == `SSC_LEN_ZERO) ? `SSC_LEN_FULL : {1'b0, bit_len_ff};

  // master transfer timing: one bit per peripheral clock period
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      mst_st_ff <= ssc_pkg::ssc_m_idle;
      mst_cnt_ff <= 6'h00;
    end else begin
      case (mst_st_ff)
        ssc_pkg::ssc_m_idle: begin
          mst_cnt_ff <= 6'h00;
          if (go_wr && role_mst_ff) begin
            mst_st_ff <= ssc_pkg::ssc_m_run;
          end
        end
        ssc_pkg::ssc_m_run: begin
          if (mst_done) begin
            mst_st_ff <= ssc_pkg::ssc_m_idle;
          end else if (pclk_rise) begin
            mst_cnt_ff <= mst_cnt_ff + 6'h01;
          end
        end
        default: mst_st_ff <= ssc_pkg::ssc_m_idle;
      endcase
    end
  end
  assign mst_done = (mst_st_ff == ssc_pkg::ssc_m_run) && (mst_cnt_ff == target);

  // slave select decode, steered by the polarity and level-trigger bits
  ssc_sel_detect u_sel (
    .i_clk(i_mclk),
    .i_rst_n(rst_n),
    .i_ss(ss_s),
    .i_pol(sel_pol_ff),
    .i_level_mode(ltrig_en_ff),
    .o_active(sel_act),
    .o_end(sel_end)
  );

  // slave bit count, saturating so an overlong frame cannot wrap to a match
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      slv_cnt_ff <= 6'h00;
    end else if (sel_end) begin
      slv_cnt_ff <= 6'h00;
    end else if (sel_act && sclk_rise && (slv_cnt_ff != `SSC_CNT_MAX)) begin
      slv_cnt_ff <= slv_cnt_ff + 6'h01;
    end
  end
  assign slv_done = sel_end & ~role_mst_ff & go_ff;
  assign len_hit = (slv_cnt_ff == target);

  // go bit: set by software, cleared when the transfer or transaction ends
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      go_ff <= 1'b0;
    end else if (go_wr) begin
      go_ff <= 1'b1;
    end else if (mst_done || slv_done) begin
      go_ff <= 1'b0;
    end
  end

  // delayed clear: four peripheral clock edges, then one more system cycle
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      clr_run_ff <= 1'b0;
      clr_cnt_ff <= 3'h0;
    end else if (go_wr) begin
      clr_run_ff <= 1'b1;
      clr_cnt_ff <= 3'h0;
    end else if (flag_clr) begin
      clr_run_ff <= 1'b0;
    end else if (clr_run_ff && pclk_rise) begin
      clr_cnt_ff <= clr_cnt_ff + 3'h1;
    end
  end
  assign flag_clr = clr_run_ff && (clr_cnt_ff == `SSC_CLR_PCLK);

  // match flag; a transaction end in the clear cycle wins
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else if (fifo_en_ff) begin
      flag_ff <= 1'b0;
    end else if (slv_done) begin
      flag_ff <= len_hit;
    end else if (flag_clr) begin
      flag_ff <= 1'b0;
    end
  end

  // sticky events: done, and slave length mismatch; set beats write-one clear
  assign ev_set[`SSC_IST_DONE] = mst_done | slv_done;
  assign ev_set[`SSC_IST_MISS] = slv_done & ~len_hit;
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ist_ff <= 2'h0;
      imsk_ff <= 2'h0;
    end else begin
      if (wr_ph_ff && (addr_ff == `SSC_ADDR_IST)) begin
        ist_ff <= (ist_ff & ~i_hwdata[1:0]) | ev_set;
      end else begin
        ist_ff <= ist_ff | ev_set;
      end
      if (wr_ph_ff && (addr_ff == `SSC_ADDR_IMSK)) begin
        imsk_ff <= i_hwdata[1:0];
      end
    end
  end

  // master select drive; manual mode ignores transfer activity
  always_comb begin
    if (auto_en_ff) begin
      ss_drive_act = sel_ctl_ff && (mst_st_ff == ssc_pkg::ssc_m_run);
    end else begin
      ss_drive_act = sel_ctl_ff;
    end
  end

  // registered pin and status outputs; slave role releases the pin
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ss_out_ff <= 1'b1;
      ss_oe_ff <= 1'b0;
      busy_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ss_out_ff <= ss_drive_act ? sel_pol_ff : ~sel_pol_ff;
      ss_oe_ff <= role_mst_ff;
      busy_ff <= go_ff;
      irq_ff <= |(ist_ff & imsk_ff);
    end
  end

  assign o_hrdata = hrdata_ff;
  assign o_hreadyout = hready_ff;
  assign o_hresp = hresp_ff;
  assign o_ss_out = ss_out_ff;
  assign o_ss_oe = ss_oe_ff;
  assign o_busy = busy_ff;
  assign o_irq = irq_ff;

  // checks
  property p_flag_set;
    @(posedge i_mclk) disable iff (!rst_n)
    (slv_done && !fifo_en_ff) |=> (flag_ff == $past(len_hit));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("match flag wrong after end");

  property p_flag_clr;
    @(posedge i_mclk) disable iff (!rst_n)
    go_wr |-> ##[1:60] !flag_ff;
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("match flag not cleared");

  property p_flag_hold;
    @(posedge i_mclk) disable iff (!rst_n)
    (go_wr && flag_ff && !fifo_en_ff && !i_hwdata[`SSC_CTL_FIFO]) |=> flag_ff [*4];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("match flag cleared early");

  property p_fifo_flag;
    @(posedge i_mclk) disable iff (!rst_n)
    fifo_en_ff |=> !flag_ff;
  endproperty
  a_fifo_flag: assert property (p_fifo_flag) else $error("flag set in fifo mode");

  property p_edge_needed;
    @(posedge i_mclk) disable iff (!rst_n)
    (!ltrig_en_ff && !sel_act && (ss_s == sel_pol_ff) && $stable(ss_s)) |=> !sel_act;
  endproperty
  a_edge_needed: assert property (p_edge_needed) else $error("active without edge");

  property p_level_act;
    @(posedge i_mclk) disable iff (!rst_n)
    (ltrig_en_ff && $stable(ltrig_en_ff)) |=> (sel_act == $past(ss_s == sel_pol_ff));
  endproperty
  a_level_act: assert property (p_level_act) else $error("level select mismatch");

  property p_manual;
    @(posedge i_mclk) disable iff (!rst_n)
    !auto_en_ff |=> (o_ss_out == ($past(sel_ctl_ff) ~^ $past(sel_pol_ff)));
  endproperty
  a_manual: assert property (p_manual) else $error("manual select drive wrong");

  property p_auto_idle;
    @(posedge i_mclk) disable iff (!rst_n)
    (auto_en_ff && (mst_st_ff == ssc_pkg::ssc_m_idle)) |=> (o_ss_out == !$past(sel_pol_ff));
  endproperty
  a_auto_idle: assert property (p_auto_idle) else $error("auto select active idle");

  property p_start;
    @(posedge i_mclk) disable iff (!rst_n)
    (go_wr && role_mst_ff && (mst_st_ff == ssc_pkg::ssc_m_idle))
      |=> (mst_st_ff == ssc_pkg::ssc_m_run) && go_ff;
  endproperty
  a_start: assert property (p_start) else $error("go did not start");

  property p_len_full;
    @(posedge i_mclk) disable iff (!rst_n)
    (bit_len_ff == `SSC_LEN_ZERO) |-> (target == `SSC_LEN_FULL);
  endproperty
  a_len_full: assert property (p_len_full) else $error("zero length not 32");

  property p_rsvd;
    @(posedge i_mclk) disable iff (!rst_n)
    (rd_ph_ff && (addr_ff == `SSC_ADDR_SEL)) |=> (o_hrdata[31:6] == 26'h0) && !o_hrdata[1];
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

  property p_slave_oe;
    @(posedge i_mclk) disable iff (!rst_n)
    !role_mst_ff |=> !o_ss_oe;
  endproperty
  a_slave_oe: assert property (p_slave_oe) else $error("slave drives select");

  c_mst_done: cover property (@(posedge i_mclk) disable iff (!rst_n) mst_done && auto_en_ff);
  c_slv_hit: cover property (@(posedge i_mclk) disable iff (!rst_n) slv_done && len_hit);
  c_slv_miss: cover property (@(posedge i_mclk) disable iff (!rst_n) slv_done && !len_hit);
  c_flag_clr: cover property (@(posedge i_mclk) disable iff (!rst_n) flag_clr && flag_ff);
endmodule : ssc_top

// [src/ssc_consts.svh]
// register map, field positions and reset values of the select control block
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH
`define SSC_ADDR_CTRL 8'h00
`define SSC_ADDR_SEL 8'h08
`define SSC_ADDR_IST 8'h40
`define SSC_ADDR_IMSK 8'h44
`define SSC_CTL_GO 0
`define SSC_CTL_MST 1
`define SSC_CTL_FIFO 2
`define SSC_CTL_LEN_LO 8
`define SSC_CTL_LEN_HI 12
`define SSC_SEL_CTL 0
`define SSC_SEL_POL 2
`define SSC_SEL_AUTO 3
`define SSC_SEL_LTRIG 4
`define SSC_SEL_FLAG 5
`define SSC_IST_DONE 0
`define SSC_IST_MISS 1
`define SSC_LEN_ZERO 5'h00
`define SSC_LEN_FULL 6'h20
`define SSC_CNT_MAX 6'h3f
`define SSC_CLR_PCLK 3'h4
`define SSC_ZERO32 32'h00000000
`define SSC_RESP_OKAY 1'h0
`endif

// [src/ssc_pkg.sv]
// shared types of the select control block
package ssc_pkg;
  typedef enum logic [0:0] {
    ssc_m_idle,
    ssc_m_run
  } ssc_mst_state_t;
endpackage : ssc_pkg

// [src/ssc_sync.sv]
// two-flop synchroniser for pins and the peripheral clock
`timescale 1ns/1ns
module ssc_sync #(
  parameter int W = 3
) (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // synchronised reset, active low
  input wire logic [W-1:0] i_d, // asynchronous inputs
  output logic [W-1:0] o_q // synchronised copies
);
  // one pair of flops per bit; the first stage feeds only the second
  for (genvar g = 0; g < W; g++) begin : g_bit
    logic meta_ff;
    logic hold_ff;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        meta_ff <= 1'b0;
        hold_ff <= 1'b0;
      end else begin
        meta_ff <= i_d[g];
        hold_ff <= meta_ff;
      end
    end
    assign o_q[g] = hold_ff;
  end
endmodule : ssc_sync

// [src/ssc_sel_detect.sv]
// slave-side select interpretation, edge or level triggered
`timescale 1ns/1ns
module ssc_sel_detect (
  input wire logic i_clk, // system clock
  input wire logic i_rst_n, // synchronised reset, active low
  input wire logic i_ss, // synchronised select pin level
  input wire logic i_pol, // 1 = active high or rising edge
  input wire logic i_level_mode, // 1 = level triggered
  output logic o_active, // select seen as active
  output logic o_end // one-cycle pulse when active ends
);
  logic prev_ff;
  logic act_ff;
  logic end_ff;
  logic pin_act;
  logic nxt_act;
  assign pin_act = (i_ss == i_pol);
  // edge mode needs a pin change into the active level; a polarity write alone is no edge
  always_comb begin
    if (i_level_mode) begin
      nxt_act = pin_act;
    end else begin
      nxt_act = act_ff ? pin_act : (pin_act & (i_ss ^ prev_ff));
    end
  end
  // activity state and end pulse
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_ff <= 1'b0;
      act_ff <= 1'b0;
      end_ff <= 1'b0;
    end else begin
      prev_ff <= i_ss; // raw level, same reset value as the synchroniser
      act_ff <= nxt_act;
      end_ff <= act_ff & ~nxt_act;
    end
  end
  assign o_active = act_ff;
  assign o_end = end_ff;
endmodule : ssc_sel_detect

// [tb/ssc_ext_master.sv]
// behavioural external spi master that drives the select pin and bus clock
`timescale 1ns/1ns
module ssc_ext_master (
  output logic o_sclk, // bus clock, low outside frames
  output logic o_ss // select pin drive
);
  int half = 80; // half bit period; 80 is prompt, larger values are slow
  initial begin
    o_sclk = 1'h0;
    o_ss = 1'h1;
  end
  // park select at the inactive level of the chosen polarity
  task automatic park(input logic pol);
    // step off the system clock edge so the pin never moves as it is sampled
    #5;
    o_ss = ~pol;
  endtask : park
  // one whole frame; clock stands still before and after it
  task automatic frame(input int bits, input logic pol);
    #5;
    o_ss = pol;
    #(2 * half);
    repeat (bits) begin
      #half o_sclk = 1'h1;
      #half o_sclk = 1'h0;
    end
    #(2 * half);
    o_ss = ~pol;
  endtask : frame
endmodule : ssc_ext_master

// [tb/test_spi_slave_select_control.sv]
// self-checking bench of the select control block
`timescale 1ns/1ns
`include "ssc_consts.svh"
module test_spi_slave_select_control;
  logic i_mclk = 1'h0;
  logic i_resetn = 1'h0;
  logic i_hsel = 1'h0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'h0;
  logic [31:0] i_hwdata = 32'h0;
  logic i_spi_pclk = 1'h0;
  logic [31:0] o_hrdata;
  logic o_hreadyout, o_hresp, o_ss_out, o_ss_oe, o_busy, o_irq;
  logic ext_sclk, ext_ss, ss_wire;
  logic [3:0] mon;
  logic [31:0] rd;
  int error_cnt = 0;
  int n_tests = 0;
  // clocks; peripheral clock is eight system periods long, its edges on system clock falling edges
  always #10 i_mclk = ~i_mclk;
  always #80 i_spi_pclk = ~i_spi_pclk;
  // the pin carries the block's drive when enabled, else the far side's
  assign ss_wire = o_ss_oe ? o_ss_out : ext_ss;
  assign mon = {o_irq, o_busy, o_ss_out, o_ss_oe};
  ssc_top ssc_top_inst (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2), .i_hwdata(i_hwdata),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_spi_pclk(i_spi_pclk), .i_sclk(ext_sclk), .i_ss_in(ss_wire),
    .o_ss_out(o_ss_out), .o_ss_oe(o_ss_oe), .o_busy(o_busy), .o_irq(o_irq)
  );
  ssc_ext_master ssc_ext_master_inst (.o_sclk(ext_sclk), .o_ss(ext_ss));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : cyc
  // bounded wait until a monitored output reaches a level
  task automatic wait_mon(input int idx, input logic v, input int lim, input string msg);
    int n;
    n = 0;
    while (mon[idx] !== v) begin
      n++;
      if (n > lim) begin
        chk(mon[idx], v, msg);
        test_done();
      end
      @(posedge i_mclk);
    end
    n_tests++;
  endtask : wait_mon
  // edge at which ready is sampled high; a hang ends the run
  task automatic rdy_edge();
    int n;
    n = 0;
    @(posedge i_mclk);
    while (o_hreadyout !== 1'h1) begin
      n++;
      if (n > 40) begin
        chk(32'h0, 32'h1, "ready timeout");
        test_done();
      end
      @(posedge i_mclk);
    end
  endtask : rdy_edge
  // one single-word transfer; called just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    i_hsel <= 1'h1;
    i_htrans <= 2'h2;
    i_hwrite <= wr;
    i_haddr <= {24'h0, a};
    rdy_edge();
    i_htrans <= 2'h0;
    i_hsel <= 1'h0;
    i_hwdata <= wd;
    rdy_edge();
    rd = o_hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'h1, a, d);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    ahb(1'h0, a, 32'h0);
    chk(rd, exp, msg);
  endtask : rdchk
  task automatic t_regs();
    rdchk(`SSC_ADDR_SEL, 32'h0, "select reg reset");
    wr(`SSC_ADDR_SEL, 32'hffffffff);
    rdchk(`SSC_ADDR_SEL, 32'h1d, "reserved or flag bits");
    chk({31'h0, o_ss_oe}, 32'h0, "slave role drives pin");
    wr(8'h80, 32'hffffffff);
    rdchk(8'h80, 32'h0, "unmapped read");
    chk({31'h0, o_hresp}, 32'h0, "response not okay");
    $display("test regs done");
  endtask : t_regs
  task automatic t_manual();
    logic pol, ctl;
    wr(`SSC_ADDR_CTRL, 32'h2);
    for (int i = 0; i < 4; i++) begin
      pol = i[1];
      ctl = i[0];
      // level trigger bit set with ctl must not disturb master drive
      wr(`SSC_ADDR_SEL, {27'h0, ctl, 1'h0, pol, 1'h0, ctl});
      cyc(3);
      chk({31'h0, o_ss_out}, {31'h0, ctl ? pol : ~pol}, "manual select");
      chk({31'h0, o_ss_oe}, 32'h1, "master enable");
    end
    $display("test manual done");
  endtask : t_manual
  task automatic t_auto();
    int lows;
    wr(`SSC_ADDR_SEL, 32'h9);
    cyc(3);
    chk({31'h0, o_ss_out}, 32'h1, "auto idle");
    wr(`SSC_ADDR_CTRL, 32'h803);
    wait_mon(1, 1'h0, 20, "auto assert");
    wait_mon(2, 1'h0, 200, "master end");
    cyc(3);
    chk({31'h0, o_ss_out}, 32'h1, "auto release");
    wr(`SSC_ADDR_SEL, 32'h8);
    wr(`SSC_ADDR_CTRL, 32'h803);
    lows = 0;
    // the whole transfer fits in this sampling span
    repeat (100) begin
      @(posedge i_mclk);
      if (o_ss_out !== 1'h1) lows++;
    end
    chk(lows, 32'h0, "auto with ctl 0");
    wait_mon(2, 1'h0, 200, "master end");
    chk({31'h0, o_irq}, 32'h0, "masked irq");
    rdchk(`SSC_ADDR_IST, 32'h1, "done status");
    wr(`SSC_ADDR_IMSK, 32'h1);
    cyc(2);
    chk({31'h0, o_irq}, 32'h1, "irq raise");
    wr(`SSC_ADDR_IST, 32'h1);
    cyc(2);
    chk({31'h0, o_irq}, 32'h0, "irq clear");
    $display("test auto done");
  endtask : t_auto
  task automatic t_slave();
    logic pol, lvl;
    // role and length first: a go written with the role change would start a master run
    wr(`SSC_ADDR_CTRL, 32'h800);
    for (int i = 0; i < 4; i++) begin
      pol = i[0];
      lvl = i[1];
      ssc_ext_master_inst.park(pol);
      cyc(4);
      wr(`SSC_ADDR_SEL, {27'h0, lvl, 1'h0, pol, 2'h0});
      wr(`SSC_ADDR_CTRL, 32'h801);
      ssc_ext_master_inst.frame(8, pol);
      cyc(10);
      rdchk(`SSC_ADDR_SEL, {27'h1, lvl, 1'h0, pol, 2'h0}, "match flag");
    end
    // flag must survive the first peripheral clocks after go
    wr(`SSC_ADDR_CTRL, 32'h801);
    rdchk(`SSC_ADDR_SEL, 32'h34, "flag cleared early");
    cyc(50);
    rdchk(`SSC_ADDR_SEL, 32'h14, "flag not cleared");
    ssc_ext_master_inst.frame(7, 1'h1);
    cyc(10);
    rdchk(`SSC_ADDR_SEL, 32'h14, "short frame flag");
    rdchk(`SSC_ADDR_IST, 32'h3, "mismatch status");
    wr(`SSC_ADDR_IST, 32'h3);
    // zero length means 32 bits
    wr(`SSC_ADDR_CTRL, 32'h1);
    ssc_ext_master_inst.frame(32, 1'h1);
    cyc(10);
    rdchk(`SSC_ADDR_SEL, 32'h34, "32 bit frame");
    $display("test slave done");
  endtask : t_slave
  task automatic t_fifo();
    wr(`SSC_ADDR_CTRL, 32'h805);
    ssc_ext_master_inst.frame(8, 1'h1);
    cyc(10);
    rdchk(`SSC_ADDR_SEL, 32'h14, "flag in fifo mode");
    $display("test fifo done");
  endtask : t_fifo
  // main sequence
  initial begin
    repeat (6) @(posedge i_mclk);
    i_resetn <= 1'h1;
    cyc(3);
    chk({28'h0, mon}, 32'h2, "reset outputs");
    t_regs();
    t_manual();
    t_auto();
    t_slave();
    t_fifo();
    test_done();
  end
endmodule : test_spi_slave_select_control
